// ==== src/dmab_consts.svh ====
// Purpose: Shared constants of the multiply and add block
// Assumes: Included by its bare name from the design files
// Notes:   Offsets do not exist here; the block has no register bus
`ifndef DMAB_CONSTS_SVH
`define DMAB_CONSTS_SVH
`define DMAB_LANE_W       18
`define DMAB_LANES        8
`define DMAB_MULTS        4
`define DMAB_ACC_W        52
`define DMAB_GROUPS       4
`define DMAB_GRP_SAMPLE   0
`define DMAB_GRP_COEF     1
`define DMAB_GRP_CTRL     2
`define DMAB_GRP_OUT      3
`define DMAB_OPSIZE_DEF   18
`define DMAB_RST_LANE     18'h00000
`endif

// ==== src/dmab_pkg.sv ====
// Purpose: Types of the multiply and add block
// Assumes: Nothing beyond the constants header
// Notes:   Mode is fixed at elaboration
package dmab_pkg;
	typedef enum {
		dmab_mode_simple,
		dmab_mode_mac,
		dmab_mode_two_add,
		dmab_mode_four_add
	} dmab_mode_type;
endpackage

// ==== src/dmab_mult18.sv ====
// Purpose: One 18x18 multiplier that also yields two 9x9 half products
// Assumes: Sign flags apply to the top bit of each operand or half
// Notes:   All results are true signed values, so unsigned data stays positive
`include "dmab_consts.svh"
module dmab_mult18
	import dmab_pkg::*;
(
	input  wire logic [`DMAB_LANE_W-1:0] a_in,
	input  wire logic [`DMAB_LANE_W-1:0] b_in,
	input  wire logic                    a_sgn_in,
	input  wire logic                    b_sgn_in,
	output logic signed [37:0]           full_out,
	output logic signed [19:0]           lo_out,
	output logic signed [19:0]           hi_out
);
	logic signed [18:0] a_x;
	logic signed [18:0] b_x;
	logic signed [9:0]  a_l;
	logic signed [9:0]  a_h;
	logic signed [9:0]  b_l;
	logic signed [9:0]  b_h;

	assign a_x      = {a_sgn_in & a_in[17], a_in};
	assign b_x      = {b_sgn_in & b_in[17], b_in};
	assign a_l      = {a_sgn_in & a_in[8], a_in[8:0]};
	assign a_h      = {a_sgn_in & a_in[17], a_in[17:9]};
	assign b_l      = {b_sgn_in & b_in[8], b_in[8:0]};
	assign b_h      = {b_sgn_in & b_in[17], b_in[17:9]};
	assign full_out = a_x * b_x;
	assign lo_out   = a_l * b_l;
	assign hi_out   = a_h * b_h;
endmodule

// ==== src/dmab_block.sv ====
// Purpose: Four-multiplier multiply and add block with input shift chains
// Assumes: All inputs synchronous to ref_clk_in; control lines are sampled levels
// Notes:   Control clock lines act as update strobes on their rising level change
`include "dmab_consts.svh"
// How it works
// - Sample chain and coefficient chain feed FIR
// - Four-tap 18-bit FIR inside one block
// - Simple mode: eight, four or one product
// - Two 52-bit accumulators, not at 36x36
// - Two-product sums: four or two
// - Four-product sums: two or one
// - Counts hold signed or unsigned operands
// - Chains cascade to block below via last taps
// - Shift chain routed out of block
// - Eight 18-bit input and output units
// - Twenty-one-line control bus from fabric
// - Eight operand inputs, eight product lanes
// - Select high adds, low subtracts
// - Synchronous load replaces accumulated total
// - Registered unheld overflow flag in accumulate
// - One mode per block instance
module dmab_block
	import dmab_pkg::*;
#(
	parameter dmab_mode_type MODE    = dmab_mode_simple,
	parameter int            OP_SIZE = `DMAB_OPSIZE_DEF
)(
	input  wire logic                                 ref_clk_in,
	input  wire logic                                 rst_n_in,
	input  wire logic [`DMAB_MULTS*`DMAB_LANE_W-1:0]  operand_a_in,
	input  wire logic [`DMAB_MULTS*`DMAB_LANE_W-1:0]  operand_b_in,
	input  wire logic [`DMAB_GROUPS-1:0]              ctrl_clk_in,
	input  wire logic [`DMAB_GROUPS-1:0]              ctrl_aclr_in,
	input  wire logic [`DMAB_GROUPS-1:0]              ctrl_ena_in,
	input  wire logic                                 sign_a_in,
	input  wire logic                                 sign_b_in,
	input  wire logic                                 upper_add_sub_sel_in,
	input  wire logic                                 lower_add_sub_sel_in,
	input  wire logic [1:0]                           acc_sload_in,
	input  wire logic                                 shift_a_en_in,
	input  wire logic                                 chain_from_above_in,
	input  wire logic                                 coef_serial_in,
	input  wire logic [`DMAB_LANE_W-1:0]              shift_a_in,
	input  wire logic [`DMAB_LANE_W-1:0]              shift_b_in,
	output logic      [`DMAB_LANES*`DMAB_LANE_W-1:0]  product_out,
	output logic      [1:0]                           overflow_out,
	output logic      [`DMAB_LANE_W-1:0]              shift_a_out,
	output logic      [`DMAB_LANE_W-1:0]              shift_b_out
);
	localparam int  LW   = `DMAB_LANE_W;
	localparam bit  WIDE = (OP_SIZE == 36);
	localparam bit  OP9  = (OP_SIZE == 9);
	localparam bit  IS_MAC = (MODE == dmab_mode_mac);

	// no accumulate or adders at 36x36
	generate
		if (OP_SIZE != 9 && OP_SIZE != 18 && OP_SIZE != 36) begin : g_bad_size
			$error("operand size must be 9, 18 or 36");
		end
		if (WIDE && MODE != dmab_mode_simple) begin : g_bad_wide
			$error("36x36 operands only in simple multiply mode");
		end
	endgenerate

	logic [`DMAB_GROUPS-1:0] clk_line_q;
	logic [`DMAB_GROUPS-1:0] step;
	logic [`DMAB_GROUPS-1:0] clr;
	logic [LW-1:0]           a_q [`DMAB_MULTS];
	logic [LW-1:0]           b_q [`DMAB_MULTS];
	logic [LW-1:0]           a_d [`DMAB_MULTS];
	logic [LW-1:0]           b_d [`DMAB_MULTS];
	logic                    sign_a_q;
	logic                    sign_b_q;
	logic [1:0]              add_q;
	logic [1:0]              sload_q;
	logic [143:0]            result_q;
	logic [143:0]            result_d;
	logic [1:0]              ovf_q;
	logic [1:0]              ovf_d;
	logic [LW-1:0]           m_a [`DMAB_MULTS];
	logic [LW-1:0]           m_b [`DMAB_MULTS];
	logic                    m_as [`DMAB_MULTS];
	logic                    m_bs [`DMAB_MULTS];
	logic signed [37:0]      pf [`DMAB_MULTS];
	logic signed [19:0]      pl [`DMAB_MULTS];
	logic signed [19:0]      ph [`DMAB_MULTS];
	logic                    a_shift;
	logic                    b_shift;

	// clock lines strobe, enables qualify, clears act per group
	assign step = ctrl_clk_in & ~clk_line_q & ctrl_ena_in;
	assign clr  = ctrl_aclr_in;

	// 36x36 has no input shift chain, so both chains load in parallel
	assign a_shift = shift_a_en_in & ~WIDE;
	assign b_shift = coef_serial_in & ~WIDE;

	// sample chain shifts or loads parallel, coefficients load serial or parallel
	// first tap may take the chain of the block above
	generate
		for (genvar i = 0; i < `DMAB_MULTS; i++) begin : g_chain
			if (i == 0) begin : g_first
				assign a_d[i] = a_shift ? (chain_from_above_in ? shift_a_in
				                          : operand_a_in[LW-1:0]) : operand_a_in[LW-1:0];
				assign b_d[i] = b_shift ? shift_b_in : operand_b_in[LW-1:0];
			end else begin : g_next
				assign a_d[i] = a_shift ? a_q[i-1] : operand_a_in[i*LW +: LW];
				assign b_d[i] = b_shift ? b_q[i-1] : operand_b_in[i*LW +: LW];
			end
			// 36x36 splits operands over the four multipliers
			assign m_a[i]  = WIDE ? a_q[i%2] : a_q[i];
			assign m_b[i]  = WIDE ? b_q[i/2] : b_q[i];
			// sign applies to upper halves only when combined
			assign m_as[i] = sign_a_q & (~WIDE | (i%2 == 1));
			assign m_bs[i] = sign_b_q & (~WIDE | (i >= 2));
			dmab_mult18 u_mult (
				.a_in     (m_a[i]),
				.b_in     (m_b[i]),
				.a_sgn_in (m_as[i]),
				.b_sgn_in (m_bs[i]),
				.full_out (pf[i]),
				.lo_out   (pl[i]),
				.hi_out   (ph[i])
			);
		end
	endgenerate

	logic signed [73:0]  wide_sum;
	logic signed [38:0]  s18 [2];
	logic signed [39:0]  four18;
	logic signed [20:0]  s9 [4];
	logic signed [21:0]  four9 [2];
	logic [143:0]        lanes9;
	logic [143:0]        lanes18;
	logic [143:0]        simple_w;
	logic [143:0]        two_w;
	logic [143:0]        four_w;
	logic [143:0]        mac_w;
	logic [51:0]         acc_q [2];
	logic [51:0]         acc_d [2];
	logic [51:0]         term [2];
	logic [52:0]         sum53 [2];
	logic                acc_sgn;

	// partial products shifted and summed into one 72-bit product
	assign wide_sum = {{36{pf[0][37]}}, pf[0]}
	                + ({{36{pf[1][37]}}, pf[1]} <<< 18)
	                + ({{36{pf[2][37]}}, pf[2]} <<< 18)
	                + ({{36{pf[3][37]}}, pf[3]} <<< 36);
	assign acc_sgn  = sign_a_q | sign_b_q;
	assign acc_q[0] = result_q[51:0];
	assign acc_q[1] = result_q[123:72];

	generate
		for (genvar k = 0; k < 2; k++) begin : g_pair
			assign s18[k] = add_q[k] ? {pf[2*k][37], pf[2*k]} + {pf[2*k+1][37], pf[2*k+1]}
			                         : {pf[2*k][37], pf[2*k]} - {pf[2*k+1][37], pf[2*k+1]};
			assign s9[2*k]   = add_q[k] ? {pl[2*k][19], pl[2*k]} + {pl[2*k+1][19], pl[2*k+1]}
			                            : {pl[2*k][19], pl[2*k]} - {pl[2*k+1][19], pl[2*k+1]};
			assign s9[2*k+1] = add_q[k] ? {ph[2*k][19], ph[2*k]} + {ph[2*k+1][19], ph[2*k+1]}
			                            : {ph[2*k][19], ph[2*k]} - {ph[2*k+1][19], ph[2*k+1]};
			// second level sums the two first-level results
			assign four9[k] = {s9[k][20], s9[k]} + {s9[2+k][20], s9[2+k]};
			// second and fourth multipliers feed the accumulators
			assign term[k]  = OP9 ? {{32{pl[2*k+1][19]}}, pl[2*k+1]}
			                      : {{14{pf[2*k+1][37]}}, pf[2*k+1]};
			// add or subtract decides accumulation direction
			assign sum53[k] = add_q[k] ? {acc_sgn & acc_q[k][51], acc_q[k]} + {term[k][51], term[k]}
			                           : {acc_sgn & acc_q[k][51], acc_q[k]} - {term[k][51], term[k]};
			assign acc_d[k] = sload_q[k] ? term[k] : sum53[k][51:0];
			// signed sign mismatch, unsigned carry or borrow
			assign ovf_d[k] = IS_MAC & ~sload_q[k] &
			                  (acc_sgn ? (sum53[k][52] ^ sum53[k][51]) : sum53[k][52]);
		end
		for (genvar i = 0; i < `DMAB_MULTS; i++) begin : g_lane
			// product lanes in order of the logic rows
			assign lanes9[i*36 +: 36]  = {ph[i][17:0], pl[i][17:0]};
			assign lanes18[i*36 +: 36] = pf[i][35:0];
		end
	endgenerate

	assign four18   = {s18[0][38], s18[0]} + {s18[1][38], s18[1]};
	assign simple_w = WIDE ? {72'h0, wide_sum[71:0]} : (OP9 ? lanes9 : lanes18);
	// four or two sums of two products
	assign two_w    = OP9 ? {{15{s9[3][20]}}, s9[3], {15{s9[2][20]}}, s9[2],
	                         {15{s9[1][20]}}, s9[1], {15{s9[0][20]}}, s9[0]}
	                      : {{33{s18[1][38]}}, s18[1], {33{s18[0][38]}}, s18[0]};
	// two or one sum of four products
	assign four_w   = OP9 ? {{50{four9[1][21]}}, four9[1], {50{four9[0][21]}}, four9[0]}
	                      : {72'h0, {32{four18[39]}}, four18};
	assign mac_w    = {20'h0, acc_d[1], 20'h0, acc_d[0]};
	// one mode selects the whole output word
	assign result_d = (MODE == dmab_mode_mac)      ? mac_w :
	                  (MODE == dmab_mode_two_add)  ? two_w :
	                  (MODE == dmab_mode_four_add) ? four_w : simple_w;

	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			clk_line_q <= '0;
		end else begin
			clk_line_q <= ctrl_clk_in;
		end
	end

	// four input taps held inside the block
	always_ff @(posedge ref_clk_in) begin
		for (int i = 0; i < `DMAB_MULTS; i++) begin
			if (!rst_n_in || clr[`DMAB_GRP_SAMPLE]) begin
				a_q[i] <= `DMAB_RST_LANE;
			end else if (step[`DMAB_GRP_SAMPLE]) begin
				a_q[i] <= a_d[i];
			end
			if (!rst_n_in || clr[`DMAB_GRP_COEF]) begin
				b_q[i] <= `DMAB_RST_LANE;
			end else if (step[`DMAB_GRP_COEF]) begin
				b_q[i] <= b_d[i];
			end
		end
	end

	// Control selects registered once to line up with the operand stage
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in || clr[`DMAB_GRP_CTRL]) begin
			sign_a_q <= 1'b0;
			sign_b_q <= 1'b0;
			add_q    <= 2'h3;
			sload_q  <= 2'h0;
		end else if (step[`DMAB_GRP_CTRL]) begin
			sign_a_q <= sign_a_in;
			sign_b_q <= sign_b_in;
			add_q    <= {lower_add_sub_sel_in, upper_add_sub_sel_in};
			sload_q  <= acc_sload_in;
		end
	end

	// Accumulators live in the output register, so it is never bypassed
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in || clr[`DMAB_GRP_OUT]) begin
			result_q <= '0;
			ovf_q    <= 2'h0;
		end else if (step[`DMAB_GRP_OUT]) begin
			result_q <= result_d;
			ovf_q    <= ovf_d;
		end
	end

	// eight 18-bit output units from one register
	assign product_out  = result_q;
	// flag follows each update, not held
	assign overflow_out = ovf_q;
	// last taps leave the block for cascading
	assign shift_a_out  = a_q[`DMAB_MULTS-1];
	assign shift_b_out  = b_q[`DMAB_MULTS-1];

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);

	out_clear_a: assert property (clr[3] |=> product_out == 144'h0)
		else $error("output clear did not zero products");
	out_hold_a: assert property (!step[3] && !clr[3] |=> $stable(product_out))
		else $error("output changed without a strobe");
	sample_shift_a: assert property (step[0] && !clr[0] && a_shift |=>
		a_q[1] == $past(a_q[0]) && a_q[3] == $past(a_q[2]))
		else $error("sample chain did not shift");
	chain_entry_a: assert property (step[0] && !clr[0] && a_shift && chain_from_above_in
		|=> shift_a_out == $past(a_q[2]) && a_q[0] == $past(shift_a_in))
		else $error("chain from above not taken");
	coef_load_a: assert property (step[1] && !clr[1] && !b_shift |=>
		b_q[2] == $past(operand_b_in[53:36]))
		else $error("coefficient parallel load wrong");
	acc_sload_a: assert property (IS_MAC && step[3] && !clr[3] && sload_q[0]
		|=> product_out[51:0] == $past(term[0]) && overflow_out[0] == 1'b0)
		else $error("accumulator load did not replace total");
	acc_add_a: assert property (IS_MAC && step[3] && !clr[3] && !sload_q[1] && add_q[1]
		|=> product_out[123:72] == $past(acc_q[1]) + $past(term[1]))
		else $error("accumulator add wrong");
	ovf_mode_a: assert property (!IS_MAC |-> overflow_out == 2'h0)
		else $error("overflow outside accumulate mode");
	simple_lane_a: assert property (MODE == dmab_mode_simple && !WIDE && !OP9
		&& step[3] && !clr[3] |=> product_out[35:0] == $past(pf[0][35:0]))
		else $error("simple product lane wrong");
endmodule

// ==== testbench/dmab_fabric.sv ====
// Purpose: Fabric rows around the block: clock lines, overflow capture, 36x36 adder stage
// Assumes: Requests change on the falling edge of ref_clk_in
// Notes:   A line is forced low for a cycle after each pulse, as the block needs
module dmab_fabric (
	input  wire logic        ref_clk_in,
	input  wire logic        rst_n_in,
	input  wire logic [3:0]  req_in,
	input  wire logic [1:0]  ovf_in,
	input  wire logic [71:0] wide_in,
	output logic      [3:0]  ctrl_clk_out = 4'h0,
	output logic      [1:0]  sticky_out,
	output logic      [71:0] wide_acc_out
);
	timeunit 1ns;
	timeprecision 1ps;

	logic took_q;

	// fabric adds the 36x36 products, one per output strobe
	always @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			took_q       <= 1'b0;
			wide_acc_out <= '0;
		end else begin
			took_q <= ctrl_clk_out[3];
			if (took_q) begin
				wide_acc_out <= wide_acc_out + wide_in;
			end
		end
	end

	always @(negedge ref_clk_in) begin
		ctrl_clk_out <= req_in & ~ctrl_clk_out;
	end

	always @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			sticky_out <= 2'h0;
		end else begin
			sticky_out <= sticky_out | ovf_in;
		end
	end
endmodule

// ==== testbench/dmab_block_bench.sv ====
// Purpose: Self-checking bench for the multiply and add block
// Assumes: Instances of every mode and operand size share all inputs
// Notes:   Inputs change on the falling edge; outputs are read a cycle later
module dmab_block_bench;
	import dmab_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic [17:0] a;
		logic [17:0] b;
		logic        sg;
		logic [35:0] p;
	} dmab_row_type;

	logic          ref_clk_in = 1'b0;
	logic          rst_n_in = 1'b0;
	logic [71:0]   opa = '0, opb = '0;
	logic [3:0]    req = 4'h0, aclr = 4'h0, ena = 4'hF, ctrl_clk;
	logic          sga = 1'b0, sgb = 1'b0, usel = 1'b1, lsel = 1'b1;
	logic [1:0]    sload = 2'h0, mov, sov, sticky;
	logic          shen = 1'b0, chain = 1'b0, coser = 1'b0;
	logic [17:0]   sha = '0, shb = '0, ssa, ssb;
	logic [143:0]  sp, mp, wp, fp, tp;
	logic [71:0]   wacc;
	int            err_total = 0, n_tests = 0, cyc = 0;
	dmab_row_type  rows [6] = '{
		'{18'h3FFFF, 18'h3FFFF, 1'b0, 36'hFFFF80001},
		'{18'h3FFFF, 18'h3FFFF, 1'b1, 36'h000000001},
		'{18'h20000, 18'h00002, 1'b1, 36'hFFFFC0000},
		'{18'h20000, 18'h00002, 1'b0, 36'h000040000},
		'{18'h12345, 18'h00010, 1'b0, 36'h000123450},
		'{18'h3FFFF, 18'h00005, 1'b1, 36'hFFFFFFFFB}};

	dmab_block #(.MODE(dmab_mode_simple), .OP_SIZE(18)) dmab_block_i (
		.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .operand_a_in(opa),
		.operand_b_in(opb), .ctrl_clk_in(ctrl_clk), .ctrl_aclr_in(aclr), .ctrl_ena_in(ena),
		.sign_a_in(sga), .sign_b_in(sgb), .upper_add_sub_sel_in(usel),
		.lower_add_sub_sel_in(lsel), .acc_sload_in(sload), .shift_a_en_in(shen),
		.chain_from_above_in(chain), .coef_serial_in(coser), .shift_a_in(sha),
		.shift_b_in(shb), .product_out(sp), .overflow_out(sov), .shift_a_out(ssa),
		.shift_b_out(ssb));

	dmab_block #(.MODE(dmab_mode_mac), .OP_SIZE(18)) mac_dmab_block_i (
		.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .operand_a_in(opa),
		.operand_b_in(opb), .ctrl_clk_in(ctrl_clk), .ctrl_aclr_in(aclr), .ctrl_ena_in(ena),
		.sign_a_in(sga), .sign_b_in(sgb), .upper_add_sub_sel_in(usel),
		.lower_add_sub_sel_in(lsel), .acc_sload_in(sload), .shift_a_en_in(shen),
		.chain_from_above_in(chain), .coef_serial_in(coser), .shift_a_in(sha),
		.shift_b_in(shb), .product_out(mp), .overflow_out(mov), .shift_a_out(),
		.shift_b_out());

	dmab_block #(.MODE(dmab_mode_simple), .OP_SIZE(36)) wide_dmab_block_i (
		.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .operand_a_in(opa),
		.operand_b_in(opb), .ctrl_clk_in(ctrl_clk), .ctrl_aclr_in(aclr), .ctrl_ena_in(ena),
		.sign_a_in(sga), .sign_b_in(sgb), .upper_add_sub_sel_in(usel),
		.lower_add_sub_sel_in(lsel), .acc_sload_in(sload), .shift_a_en_in(shen),
		.chain_from_above_in(chain), .coef_serial_in(coser), .shift_a_in(sha),
		.shift_b_in(shb), .product_out(wp), .overflow_out(), .shift_a_out(),
		.shift_b_out());

	dmab_block #(.MODE(dmab_mode_four_add), .OP_SIZE(18)) four_dmab_block_i (
		.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .operand_a_in(opa),
		.operand_b_in(opb), .ctrl_clk_in(ctrl_clk), .ctrl_aclr_in(aclr), .ctrl_ena_in(ena),
		.sign_a_in(sga), .sign_b_in(sgb), .upper_add_sub_sel_in(usel),
		.lower_add_sub_sel_in(lsel), .acc_sload_in(sload), .shift_a_en_in(shen),
		.chain_from_above_in(chain), .coef_serial_in(coser), .shift_a_in(sha),
		.shift_b_in(shb), .product_out(fp), .overflow_out(), .shift_a_out(),
		.shift_b_out());

	dmab_block #(.MODE(dmab_mode_two_add), .OP_SIZE(9)) two_dmab_block_i (
		.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .operand_a_in(opa),
		.operand_b_in(opb), .ctrl_clk_in(ctrl_clk), .ctrl_aclr_in(aclr), .ctrl_ena_in(ena),
		.sign_a_in(sga), .sign_b_in(sgb), .upper_add_sub_sel_in(usel),
		.lower_add_sub_sel_in(lsel), .acc_sload_in(sload), .shift_a_en_in(shen),
		.chain_from_above_in(chain), .coef_serial_in(coser), .shift_a_in(sha),
		.shift_b_in(shb), .product_out(tp), .overflow_out(), .shift_a_out(),
		.shift_b_out());

	dmab_fabric dmab_fabric_i (
		.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .req_in(req), .ovf_in(mov),
		.wide_in(wp[71:0]), .ctrl_clk_out(ctrl_clk), .sticky_out(sticky),
		.wide_acc_out(wacc));

	always #4 ref_clk_in = ~ref_clk_in;

	task print_verdict;
		if (err_total == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// The whole run is near 64 cycles, so 1000 only trips on a hang
	always @(posedge ref_clk_in) begin
		cyc++;
		if (cyc == 1000) begin
			err_total++;
			print_verdict();
		end
	end

	task chk(input logic [143:0] got, input logic [143:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task strobe(input logic [3:0] m);
		req <= m;
		@(negedge ref_clk_in);
		req <= 4'h0;
		@(negedge ref_clk_in);
	endtask

	task chk_mac(input logic [51:0] acc1, input logic [51:0] acc0, input logic [1:0] ov);
		chk(144'({mp[123:72], mp[51:0], mov}), 144'({acc1, acc0, ov}));
	endtask

	initial begin
		repeat (3) @(negedge ref_clk_in);
		rst_n_in <= 1'b1;
		@(negedge ref_clk_in);
		chk(sp, '0);
		chk(144'({ssa, ssb, sov, mov, sticky}), '0);
		for (int r = 0; r < 6; r++) begin
			opa <= 72'(rows[r].a) << (18 * (r % 4));
			opb <= 72'(rows[r].b) << (18 * (r % 4));
			sga <= rows[r].sg;
			sgb <= rows[r].sg;
			strobe(4'h7);
			strobe(4'h8);
			chk(sp, 144'(rows[r].p) << (36 * (r % 4)));
		end
		opa <= {18'h00002, 18'h00000, 18'h3FFFF, 18'h00000};
		opb <= {18'h00003, 18'h00000, 18'h3FFFF, 18'h00000};
		sga <= 1'b0;
		sgb <= 1'b0;
		sload <= 2'h3;
		strobe(4'h7);
		strobe(4'h8);
		chk_mac(52'h6, 52'hFFFF80001, 2'h0);
		sload <= 2'h0;
		lsel <= 1'b0;
		strobe(4'h4);
		strobe(4'h8);
		chk_mac(52'h0, 52'h1FFFF00002, 2'h0);
		strobe(4'h8);
		chk_mac(52'hFFFFFFFFFFFFA, 52'h2FFFE80003, 2'h2);
		sload <= 2'h2;
		strobe(4'h4);
		strobe(4'h8);
		chk_mac(52'h6, 52'h3FFFE00004, 2'h0);
		chk(144'(sticky), 144'h2);
		ena <= 4'h7;
		strobe(4'h8);
		chk_mac(52'h6, 52'h3FFFE00004, 2'h0);
		ena <= 4'hF;
		aclr <= 4'h8;
		@(negedge ref_clk_in);
		aclr <= 4'h0;
		chk_mac(52'h0, 52'h0, 2'h0);
		shen <= 1'b1;
		chain <= 1'b1;
		coser <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			sha <= 18'(i + 1);
			shb <= 18'(i + 11);
			strobe(4'h3);
		end
		chk(144'({ssa, ssb}), 144'({18'h00001, 18'h0000B}));
		// Mid-run reset clears the block registers, sets add_q to add, and clears the fabric capture
		rst_n_in <= 1'b0;
		shen <= 1'b0;
		chain <= 1'b0;
		coser <= 1'b0;
		@(negedge ref_clk_in);
		rst_n_in <= 1'b1;
		@(negedge ref_clk_in);
		chk(sp, '0);
		chk(mp, '0);
		chk(144'({ssa, ssb, sov, mov, sticky}), '0);
		opa <= {18'h00004, 18'h00002, 18'h00001, 18'h00003};
		opb <= {18'h00006, 18'h00003, 18'h00001, 18'h00005};
		lsel <= 1'b1;
		strobe(4'h7);
		strobe(4'h8);
		chk(wp, 144'h100020000F);
		chk(fp, 144'h2E);
		chk(tp, {36'h0, 36'h1E, 36'h0, 36'h10});
		opa <= {18'h00001, 18'h00002, 18'h3FFFF, 18'h3FFFF};
		opb <= {18'h3FFFF, 18'h00003, 18'h00000, 18'h00402};
		sga <= 1'b1;
		sgb <= 1'b1;
		usel <= 1'b0;
		lsel <= 1'b0;
		strobe(4'h7);
		strobe(4'h8);
		chk(wp, {72'h0, -72'h402});
		chk(fp, {72'h0, -72'h3FB});
		chk(tp, {36'h0, 36'h7, -36'h2, -36'h2});
		@(negedge ref_clk_in);
		chk(144'(wacc), 144'h10001FFC0D);
		print_verdict();
	end
endmodule
